// ---- mac_mode_flags_and_address_mask_test.sv ----
/*
  self-checking bench for the mac control block.
  assumes package, design, pipeline model and checker compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %h got %h", n, e, g); err_count++; end end
module mac_mode_flags_and_address_mask_test;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              status_wr = 1'b0;
  logic [7:0]        status_wdata = 8'h00;
  logic              filter_wr = 1'b0;
  logic [15:0]       filter_wdata = 16'h0000;
  logic              prod_valid = 1'b0;
  logic [63:0]       prod_in = 64'h0;
  logic              store_valid = 1'b0;
  logic [31:0]       store_acc = 32'h0;
  logic [7:0]        status_rdata;
  logic [15:0]       filter_rdata;
  logic              prod_out_valid, store_out_valid, saturate_signed;
  logic [31:0]       prod_out, store_out;
  mmf_pkg::mode_type arith_mode;
  logic              overflow_saturate_enable, op_valid, op_overflow;
  mmf_pkg::op_type   op_kind;
  logic [31:0]       op_result, address_register, operand_address;
  logic              addr_req, addr_valid, address_register_wr;
  mmf_pkg::ea_type   addr_mode;
  logic [15:0]       ext_word, extended_displacement;
  logic [31:0]       address_register_new;
  int                err_count = 0;
  int                checked = 0;
  int                cycles = 0;

  mmf_mac_control i_dut (.*);
  mmf_pipe_model  i_pipe (.*);

  initial forever #12.5 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic wr_status(input logic [7:0] d);
    status_wdata = d;
    status_wr = 1'b1;
    cyc(1);
    status_wr = 1'b0;
  endtask

  task automatic t_reset;
    `CHK("status", 8'h00, status_rdata)
    `CHK("filter", 16'hFFFF, filter_rdata)
    $display("test reset done");
  endtask

  task automatic t_modes;
    logic [7:0]        d;
    mmf_pkg::mode_type m;
    for (int i = 0; i < 4; i++)
    begin
      d = {1'b1, i[1], i[0], 5'h1F};
      m = i[0] ? mmf_pkg::MODE_SIGNED_FRAC : i[1] ?
          mmf_pkg::MODE_UNSIGNED_INT : mmf_pkg::MODE_SIGNED_INT;
      wr_status(d);
      `CHK("status", d & 8'hFE, status_rdata)
      cyc(1);
      `CHK("mode", m, arith_mode)
      `CHK("sat_en", 1'b1, overflow_saturate_enable)
      `CHK("sat_sign", i[0] | !i[1], saturate_signed)
    end
    $display("test modes done");
  endtask

  task automatic t_flags;
    wr_status(8'h00);
    i_pipe.issue_op(mmf_pkg::OP_MAC, 32'h8000_0000, 1'b1);
    `CHK("nzv mac", 3'b101, status_rdata[3:1])
    `CHK("sat_en", 1'b0, overflow_saturate_enable)
    i_pipe.issue_op(mmf_pkg::OP_MULS, 32'h0, 1'b0);
    `CHK("nzv muls", 3'b101, status_rdata[3:1])
    i_pipe.issue_op(mmf_pkg::OP_MSAC, 32'h0, 1'b0);
    `CHK("nzv msac", 3'b011, status_rdata[3:1])
    i_pipe.issue_op(mmf_pkg::OP_MULU, 32'h8000_0000, 1'b1);
    `CHK("nzv mulu", 3'b011, status_rdata[3:1])
    i_pipe.issue_op(mmf_pkg::OP_LOAD_ACC, 32'h7FFF_FFFF, 1'b1);
    `CHK("nzv load", 3'b000, status_rdata[3:1])
    $display("test flags done");
  endtask

  task automatic t_round;
    logic [7:0]  st [6] = '{8'h30, 8'h30, 8'h30, 8'h20, 8'h70, 8'h50};
    logic [31:0] es;
    logic [63:0] pv [6] = '{64'h1_8000_0000, 64'h2_8000_0000,
      64'h2_8000_0001, 64'h1_FFFF_FFFF, 64'h3_8000_0000, 64'h1_8000_0000};
    logic [31:0] ex [6] = '{32'h2, 32'h2, 32'h3, 32'h1, 32'h4, 32'h1};
    for (int i = 0; i < 6; i++)
    begin
      wr_status(st[i]);
      prod_in = pv[i];
      store_acc = 32'h0003_8000;
      prod_valid = 1'b1;
      store_valid = 1'b1;
      cyc(1);
      prod_valid = 1'b0;
      store_valid = 1'b0;
      es = (st[i][6] & st[i][5]) ? 32'h0000_0004 : 32'h0003_8000;
      `CHK("prod", ex[i], prod_out)
      `CHK("prod_v", 1'b1, prod_out_valid)
      `CHK("store", es, store_out)
      `CHK("store_v", 1'b1, store_out_valid)
    end
    cyc(1);
    `CHK("prod_v", 1'b0, prod_out_valid)
    `CHK("store_v", 1'b0, store_out_valid)
    $display("test round done");
  endtask

  task automatic t_addr;
    mmf_pkg::ea_type md [5] = '{mmf_pkg::EA_INDIRECT, mmf_pkg::EA_POSTINC,
      mmf_pkg::EA_PREDEC, mmf_pkg::EA_DISP, mmf_pkg::EA_POSTINC};
    logic [15:0] ew [5] = '{16'h0020, 16'h0020, 16'h0020, 16'h0020, 16'hFFDF};
    logic [31:0] ar [5] = '{32'h1234_56FC, 32'h1FC, 32'h100, 32'h110, 32'h1FC};
    logic [31:0] oa [5] = '{32'h1234_00FC, 32'h1FC, 32'hFC, 32'h0, 32'h1FC};
    logic [31:0] nw [5] = '{32'h0, 32'h0, 32'hFC, 32'h0, 32'h200};
    filter_wdata = 16'h00FF;
    filter_wr = 1'b1;
    cyc(1);
    filter_wr = 1'b0;
    `CHK("filter", 16'h00FF, filter_rdata)
    for (int i = 0; i < 5; i++)
    begin
      // masked post-increment (i == 1) drives the circular queue wrap; unmasked one (i == 4) does not
      i_pipe.issue_addr(md[i], ew[i], ar[i], 16'hFFF0);
      `CHK("valid", 1'b1, addr_valid)
      `CHK("oa", oa[i], operand_address)
      `CHK("wr", i == 1 || i == 2 || i == 4, address_register_wr)
      if (i == 1 || i == 2 || i == 4)
        `CHK("new", nw[i], address_register_new)
    end
    $display("test addr done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      finish_test;
    end
  end

  initial
  begin
    cyc(12);
    arst_n = 1'b1;
    cyc(4);
    t_reset;
    t_modes;
    t_flags;
    t_round;
    t_addr;
    finish_test;
  end
endmodule

bind mmf_mac_control mmf_mac_monitor i_mon (.*);
`default_nettype wire

// ---- mmf_addr_filter.sv ----
/*
  operand address former for multiply-accumulate-with-move operations,
  with optional masking by the address filter register.
  assumes a single clock and a reset already synchronised by the top.
*/
`timescale 1ns/100ps
`default_nettype none

module mmf_addr_filter
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // request
  input  wire logic            req,
  input  wire mmf_pkg::ea_type mode,
  input  wire logic            mask_en,
  input  wire logic [31:0]     address_register,
  input  wire logic [15:0]     extended_displacement,
  input  wire logic [15:0]     filter,
  // result
  output logic                 valid,
  output logic [31:0]          operand_address,
  output logic [31:0]          next_address_register,
  output logic                 write_back
);

  logic [31:0] pattern;
  logic [31:0] mask_bits;
  logic [31:0] plus4;
  logic [31:0] minus4;
  logic [31:0] disp_sum;
  logic [31:0] next_oa;
  logic [31:0] next_ar;
  logic        next_wb;

  assign pattern   = {mmf_pkg::FILTER_UPPER, filter};
  assign mask_bits = mask_en ? pattern : 32'hFFFF_FFFF;
  assign plus4     = address_register + mmf_pkg::ADDR_STEP;
  assign minus4    = address_register - mmf_pkg::ADDR_STEP;
  assign disp_sum  = address_register
                   + {{16{extended_displacement[15]}}, extended_displacement};

  always_comb
  begin
    next_oa = address_register & mask_bits;
    next_ar = address_register;
    next_wb = 1'b0;
    case (mode)
      mmf_pkg::EA_INDIRECT:
      begin
        next_oa = address_register & mask_bits;
      end
      mmf_pkg::EA_POSTINC:
      begin
        next_oa = address_register;
        next_ar = plus4 & mask_bits;
        next_wb = 1'b1;
      end
      mmf_pkg::EA_PREDEC:
      begin
        next_oa = minus4 & mask_bits;
        next_ar = minus4 & mask_bits;
        next_wb = 1'b1;
      end
      mmf_pkg::EA_DISP:
      begin
        next_oa = disp_sum & mask_bits;
      end
      default:
      begin
        next_oa = address_register;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid                 <= 1'b0;
      operand_address       <= 32'h0000_0000;
      next_address_register <= 32'h0000_0000;
      write_back            <= 1'b0;
    end
    else
    begin
      valid                 <= req;
      operand_address       <= next_oa;
      next_address_register <= next_ar;
      write_back            <= req & next_wb;
    end
  end

endmodule

`default_nettype wire

// ---- mmf_mac_control.sv ----
/*
  mode control, condition flags and operand address filtering of a
  multiply-accumulate unit, plus product rounding for fraction mode.
  assumes the core pipeline issues one operation per cycle with its
  result, and reaches the two registers through its own move ports.
*/
//
// Function
// - bit 5 selects fraction or integer operand interpretation.
// - fractions span -1 up to just under 1, 16 or 32 bits.
// - round_select clear truncates low product half in fraction mode.
// - round_select set rounds 64-bit product to nearest, ties even.
// - negative flag follows result msb, only accumulate and load ops.
// - zero flag marks zero result, only accumulate and load ops.
// - overflow sticks until accumulator load or status write.
// - carry bit always reads zero.
// - integer mode: sign_select 0 signed, 1 unsigned; rounding ignored.
// - fraction mode always signed; sign_select picks store rounding.
// - mask pattern is upper 0xFFFF, lower filter register.
// - masking only when extension word bit 5 is set.
// - indirect mode: address register ANDed with pattern.
// - post-increment: raw address used, register plus 4 masked.
// - pre-decrement: register minus 4 masked, used and written.
// - displacement sign-extended, added, then masked.
// - integer mode sign_select sets signedness and saturation limits.
// - filter resets to all ones, status to zero.
`timescale 1ns/100ps
`default_nettype none

module mmf_mac_control
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            arst_n,
  // status register move port
  input  wire logic            status_wr,
  input  wire logic [7:0]      status_wdata,
  output logic [7:0]           status_rdata,
  // filter register move port
  input  wire logic            filter_wr,
  input  wire logic [15:0]     filter_wdata,
  output logic [15:0]          filter_rdata,
  // operation from pipeline
  input  wire logic            op_valid,
  input  wire mmf_pkg::op_type op_kind,
  input  wire logic [31:0]     op_result,
  input  wire logic            op_overflow,
  // fraction product rounding
  input  wire logic            prod_valid,
  input  wire logic [63:0]     prod_in,
  output logic                 prod_out_valid,
  output logic [31:0]          prod_out,
  // accumulator store rounding
  input  wire logic            store_valid,
  input  wire logic [31:0]     store_acc,
  output logic                 store_out_valid,
  output logic [31:0]          store_out,
  // decoded modes
  output mmf_pkg::mode_type    arith_mode,
  output logic                 saturate_signed,
  output logic                 overflow_saturate_enable,
  // operand address request
  input  wire logic            addr_req,
  input  wire mmf_pkg::ea_type addr_mode,
  input  wire logic [15:0]     ext_word,
  input  wire logic [31:0]     address_register,
  input  wire logic [15:0]     extended_displacement,
  output logic                 addr_valid,
  output logic [31:0]          operand_address,
  output logic [31:0]          address_register_new,
  output logic                 address_register_wr
);

  logic       rst_meta;
  logic       rst_n;
  logic [7:0] status;
  logic [15:0] filter;

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // field views
  wire sat_en    = status[mmf_pkg::POS_SAT];
  wire sign_sel  = status[mmf_pkg::POS_SIGN];
  wire frac_mode = status[mmf_pkg::POS_FRAC];
  wire round_sel = status[mmf_pkg::POS_ROUND];
  wire ovf_flag  = status[mmf_pkg::POS_OVF];

  function automatic logic flag_op(input mmf_pkg::op_type k);
    flag_op = (k == mmf_pkg::OP_MAC) || (k == mmf_pkg::OP_MSAC)
           || (k == mmf_pkg::OP_LOAD_ACC);
  endfunction

  // round to nearest, ties to even, of a value split into hi and lo
  function automatic logic round_up(input logic lo_msb,
                                    input logic lo_rest_nz,
                                    input logic hi_lsb);
    round_up = lo_msb & (lo_rest_nz | hi_lsb);
  endfunction

  wire flag_upd = op_valid & flag_op(op_kind);
  wire acc_load = op_valid & (op_kind == mmf_pkg::OP_LOAD_ACC);

  wire next_neg  = op_result[31];
  wire next_zero = (op_result == 32'h0000_0000);
  // a direct write replaces the flag, a load clears it
  wire ovf_kept  = status_wr ? status_wdata[mmf_pkg::POS_OVF]
                             : (ovf_flag & ~acc_load);
  // set wins over a clear; a load drops its own overflow
  wire next_ovf  = ovf_kept | (flag_upd & op_overflow & ~acc_load);

  // next status
  logic [7:0] next_status;
  always_comb
  begin
    next_status = status;
    if (status_wr)
    begin
      next_status = status_wdata;
    end
    // n and z of a finishing op win over a same-cycle write
    if (flag_upd)
    begin
      next_status[mmf_pkg::POS_NEG]  = next_neg;
      next_status[mmf_pkg::POS_ZERO] = next_zero;
    end
    next_status[mmf_pkg::POS_OVF]   = next_ovf;
    next_status[mmf_pkg::POS_CARRY] = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status <= mmf_pkg::STATUS_RESET;
    end
    else
    begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filter <= mmf_pkg::FILTER_RESET;
    end
    else if (filter_wr)
    begin
      filter <= filter_wdata;
    end
  end

  // read copies show the value after the edge, straight from a flop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_rdata <= mmf_pkg::STATUS_RESET;
    end
    else
    begin
      status_rdata <= next_status;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filter_rdata <= mmf_pkg::FILTER_RESET;
    end
    else
    begin
      filter_rdata <= filter_wr ? filter_wdata : filter;
    end
  end

  // mode decode
  mmf_pkg::mode_type next_mode;
  assign next_mode = frac_mode ? mmf_pkg::MODE_SIGNED_FRAC :
                     (sign_sel ? mmf_pkg::MODE_UNSIGNED_INT
                               : mmf_pkg::MODE_SIGNED_INT);

  // decoded mode lags the status register by one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arith_mode <= mmf_pkg::MODE_SIGNED_INT;
    end
    else
    begin
      arith_mode <= next_mode;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      saturate_signed <= 1'b1;
    end
    else
    begin
      saturate_signed <= frac_mode | ~sign_sel;
    end
  end

  // saturation itself lives in the accumulator path
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overflow_saturate_enable <= 1'b0;
    end
    else
    begin
      overflow_saturate_enable <= sat_en;
    end
  end

  // product rounding; the 64-bit product of two signed fractions
  // carries its binary point below bit 63, so upper half is q31
  wire [31:0] prod_hi  = prod_in[63:32];
  wire [31:0] prod_lo  = prod_in[31:0];
  wire        prod_up  = round_up(prod_lo[31], |prod_lo[30:0], prod_hi[0]);
  logic [31:0] next_prod;
  always_comb
  begin
    next_prod = prod_hi;
    if (frac_mode && round_sel && prod_up)
    begin
      next_prod = prod_hi + 32'h0000_0001;
    end
    else
    begin
      next_prod = prod_hi;
    end
  end

  // strobe follows the product by one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prod_out_valid <= 1'b0;
    end
    else
    begin
      prod_out_valid <= prod_valid;
    end
  end

  // data flop runs free; only the strobe qualifies it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prod_out <= 32'h0000_0000;
    end
    else
    begin
      prod_out <= next_prod;
    end
  end

  // accumulator store; rounding never alters the accumulator itself
  wire        st_up = round_up(store_acc[15], |store_acc[14:0], store_acc[16]);
  wire [15:0] st_hi = store_acc[31:16];
  logic [31:0] next_store;
  // round-to-16 on stores in fraction mode with sign_select set
  assign next_store = (frac_mode && sign_sel)
                    ? {16'h0000, 16'(st_hi + {15'h0000, st_up})}
                    : store_acc;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      store_out_valid <= 1'b0;
    end
    else
    begin
      store_out_valid <= store_valid;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      store_out <= 32'h0000_0000;
    end
    else
    begin
      store_out <= next_store;
    end
  end

  // operand address forming
  // extension word bit 5 enables mask
  mmf_addr_filter u_addr
  (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .req                   (addr_req),
    .mode                  (addr_mode),
    .mask_en               (ext_word[mmf_pkg::POS_EXT_MSK]),
    .address_register      (address_register),
    .extended_displacement (extended_displacement),
    .filter                (filter),
    .valid                 (addr_valid),
    .operand_address       (operand_address),
    .next_address_register (address_register_new),
    .write_back            (address_register_wr)
  );

endmodule

`default_nettype wire

// ---- mmf_mac_monitor.sv ----
/*
  checker for the mac control block: flags, modes, masked addresses.
  assumes a bind onto the top module, connected by port names.
*/
`timescale 1ns/100ps
`default_nettype none
module mmf_mac_monitor
(
  // clock and reset
  input wire logic              clk,
  input wire logic              arst_n,
  // registers and flags
  input wire logic              status_wr,
  input wire logic [7:0]        status_rdata,
  input wire logic [15:0]       filter_rdata,
  input wire logic              op_valid,
  input wire mmf_pkg::op_type   op_kind,
  input wire logic [31:0]       op_result,
  input wire mmf_pkg::mode_type arith_mode,
  // addressing
  input wire logic              addr_req,
  input wire mmf_pkg::ea_type   addr_mode,
  input wire logic [15:0]       ext_word,
  input wire logic [31:0]       address_register,
  input wire logic [31:0]       operand_address,
  input wire logic [31:0]       address_register_new,
  input wire logic              address_register_wr
);
  wire logic        is_load = op_valid && op_kind == mmf_pkg::OP_LOAD_ACC;
  wire logic        is_mac  = op_kind == mmf_pkg::OP_MAC;
  wire logic        is_msac = op_kind == mmf_pkg::OP_MSAC;
  wire logic        flag_op = is_load || op_valid && (is_mac || is_msac);
  wire logic        is_mul  = op_valid && (op_kind == mmf_pkg::OP_MULS ||
                                           op_kind == mmf_pkg::OP_MULU);
  wire logic        res_neg  = op_result[31];
  wire logic        res_zero = op_result == 32'h0000_0000;
  wire logic [31:0] mask = {16'hFFFF, ext_word[5] ? filter_rdata : 16'hFFFF};
  wire logic [31:0] dec_mask = (address_register - 32'h0000_0004) & mask;
  mmf_pkg::mode_type exp_mode;
  assign exp_mode = status_rdata[5] ? mmf_pkg::MODE_SIGNED_FRAC :
                    status_rdata[6] ? mmf_pkg::MODE_UNSIGNED_INT :
                    mmf_pkg::MODE_SIGNED_INT;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_carry_zero:
    assert property (status_rdata[0] == 1'b0) else $error("carry set");
  chk_neg_follows:
    assert property (flag_op |=> status_rdata[3] == $past(res_neg))
      else $error("negative flag wrong");
  chk_zero_follows:
    assert property (flag_op |=> status_rdata[2] == $past(res_zero))
      else $error("zero flag wrong");
  chk_mul_keeps_flags:
    assert property (is_mul && !status_wr |=> $stable(status_rdata[3:1]))
      else $error("multiply changed flags");
  chk_ovf_sticky:
    assert property (status_rdata[1] && !status_wr && !is_load
                     |=> status_rdata[1]) else $error("overflow dropped");
  chk_load_clears:
    assert property (is_load |=> !status_rdata[1])
      else $error("load kept overflow");
  chk_mode_decode:
    assert property (1'b1 |=> arith_mode == $past(exp_mode))
      else $error("mode decode wrong");
  chk_postinc_raw:
    assert property (addr_req && addr_mode == mmf_pkg::EA_POSTINC |=>
      address_register_wr && operand_address == $past(address_register))
      else $error("post-increment address wrong");
  chk_predec_masked:
    assert property (addr_req && addr_mode == mmf_pkg::EA_PREDEC |=>
      address_register_wr && operand_address == address_register_new &&
      operand_address == $past(dec_mask)) else $error("pre-decrement wrong");

  cover property (flag_op && res_zero);
  cover property (addr_req && ext_word[5] && addr_mode == mmf_pkg::EA_DISP);
  cover property (status_wr && status_rdata[1]);
endmodule
`default_nettype wire

// ---- mmf_pipe_model.sv ----
/*
  model of the core pipeline: completes accumulate operations and
  issues operand address requests. assumes a bench calls its tasks.
*/
`timescale 1ns/100ps
`default_nettype none
module mmf_pipe_model
(
  // clock
  input  wire logic           clk,
  // operation completion
  output var logic            op_valid,
  output var mmf_pkg::op_type op_kind,
  output var logic [31:0]     op_result,
  output var logic            op_overflow,
  // operand address request
  output var logic            addr_req,
  output var mmf_pkg::ea_type addr_mode,
  output var logic [15:0]     ext_word,
  output var logic [31:0]     address_register,
  output var logic [15:0]     extended_displacement
);
  initial
  begin
    op_valid = 1'b0;
    op_kind = mmf_pkg::OP_NONE;
    op_result = 32'h0000_0000;
    op_overflow = 1'b0;
    addr_req = 1'b0;
    addr_mode = mmf_pkg::EA_INDIRECT;
    ext_word = 16'h0000;
    address_register = 32'h0000_0000;
    extended_displacement = 16'h0000;
  end

  task automatic issue_op(input mmf_pkg::op_type k, input logic [31:0] r,
                          input logic v);
    @(posedge clk);
    #2;
    op_kind = k;
    op_result = r;
    op_overflow = v;
    op_valid = 1'b1;
    @(posedge clk);
    #2;
    op_valid = 1'b0;
    // idle result bus does not keep the last value
    op_result = ~r;
    op_overflow = ~v;
  endtask

  task automatic issue_addr(input mmf_pkg::ea_type m, input logic [15:0] e,
                            input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    #2;
    addr_mode = m;
    ext_word = e;
    address_register = a;
    extended_displacement = d;
    addr_req = 1'b1;
    @(posedge clk);
    #2;
    addr_req = 1'b0;
    address_register = ~a;
    extended_displacement = ~d;
  endtask
endmodule
`default_nettype wire

// ---- mmf_pkg.sv ----
/*
  package for the mac mode, flags and address filter block: register
  layout, reset values, operation and addressing codes.
  assumes nothing beyond a systemverilog compiler.
*/
package mmf_pkg;

  // status/control and extension word bit positions
  localparam int unsigned POS_SAT     = 7;
  localparam int unsigned POS_SIGN    = 6;
  localparam int unsigned POS_FRAC    = 5;
  localparam int unsigned POS_ROUND   = 4;
  localparam int unsigned POS_NEG     = 3;
  localparam int unsigned POS_ZERO    = 2;
  localparam int unsigned POS_OVF     = 1;
  localparam int unsigned POS_CARRY   = 0;
  localparam int unsigned POS_EXT_MSK = 5;

  // reset values and upper half of the mask pattern
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [15:0] FILTER_RESET = 16'hFFFF;
  localparam logic [15:0] FILTER_UPPER = 16'hFFFF;

  // address step for auto modes
  localparam logic [31:0] ADDR_STEP    = 32'h0000_0004;

  // half-way point of the discarded product half
  localparam logic [31:0] HALF_LSB     = 32'h8000_0000;

  // operation classes issued by the pipeline
  typedef enum logic [2:0] {
    OP_NONE,
    OP_MAC,
    OP_MSAC,
    OP_LOAD_ACC,
    OP_MULS,
    OP_MULU
  } op_type;

  // effective address modes
  typedef enum logic [1:0] {
    EA_INDIRECT,
    EA_POSTINC,
    EA_PREDEC,
    EA_DISP
  } ea_type;

  // decoded arithmetic mode
  typedef enum logic [1:0] {
    MODE_SIGNED_INT,
    MODE_UNSIGNED_INT,
    MODE_SIGNED_FRAC
  } mode_type;

endpackage
